// ===== verilog/hslr_port.sv
// Hot swap and lane sync recovery control for one serial port
//
// Summary of operation
// R1: Link-up event sets when isolated and link just trained, or while the force bit is set; write clears.
// R2: Isolated with link-up event and enable keeps interrupt asserted.
// R3: Clearing the link-up event stops its interrupt.
// R4: Simultaneous activity of several ports yields one port-write.
// R5: Port-write on each link initialisation while isolated.
// R6: Isolation drops fabric packets, flushes queues, refuses partner packets.
// R7: Removal: not-trained sets, usable clears, both stops set, fatal later.
// R8: Odd port partner loss may flag fatal on the even port.
// R9: Software programs our transmit ackID before the partner's.
// R10: AckID mismatch from bad ordering is a fatal link error.
// R11: Partner without recovery registers: set our receive ackID to zero.
// R12: Insertion: power, isolate, insert, clear stops, link request, resync.
// R13: Software clears isolation and sets the permit bits.
// R14: Software may poll usable and not-trained flags.
// R15: Sync loss on removal with enable set raises interrupt or port-write.
// R16: Sync loss restarts training and pauses ack timeout timer.
// R17: Time-to-live timer keeps running during sync loss.
// R18: Software sets time-to-live longer than the silence timer.
// R19: After resync, timers resume with the next unsent packet and ackID.
// R20: No acknowledgements while input-error-stopped.
// R21: Link-request/input-status ends input-error-stopped.
// R22: Answer link-request with link-response carrying next expected ackID.
// R23: Accept the retransmitted packet with the indicated ackID.
// R24: While isolated only link request and response symbols pass.
// R25: Permit bits gate non-maintenance transmit and receive.
// R26: Lane sync watchdog counts fixed symbol periods, then flags fatal.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "hslr_consts.svh"
module hslr_port (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Lane status pins
    input  wire logic        laneSyncPin,
    input  wire logic        symbolTick,
    input  wire logic        oddPartnerFatal,
    input  wire logic        otherPortsUp,
    // Received control symbols and packets
    input  wire logic        rxLinkReq,
    input  wire logic        rxPktValid,
    input  wire logic        rxPktMaint,
    input  wire logic [5:0]  rxPktAckId,
    // Fabric transmit request
    input  wire logic        txReqValid,
    input  wire logic        txReqMaint,
    input  wire logic        ttlExpired,
    // Outputs
    output logic             irq,
    output logic             portWrite,
    output logic             linkRespSend,
    output logic [5:0]       linkRespAckId,
    output logic             rxAck,
    output logic             rxAccept,
    output logic             txSend,
    output logic             txDrop,
    output logic [5:0]       txAckId,
    output logic             queueFlush,
    output logic             ackTimerRun,
    output logic             ttlTimerRun,
    output logic             trainRestart
);
    logic laneSync;
    hslr_sync2 #(.W(1)) uSync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .din     (laneSyncPin),
        .dout    (laneSync)
    );

    hslr_pkg::hslr_link_t linkSt_q;
    logic [5:0]  ctrl_q;
    logic        linkUp_q;
    logic        syncLostEv_q;
    logic        inStop_q;
    logic        outStop_q;
    logic        mismatch_q;
    logic [5:0]  rxExp_q;
    logic [5:0]  txNext_q;
    logic [19:0] wdog_q;
    logic        syncPrev_q;

    logic wrEn;
    logic isolate;
    logic rxAcceptNext;
    logic txSendNext;
    logic linkOk;
    logic trainedNow;
    logic lostNow;
    logic wdogDone;
    logic addrOk;
    assign wrEn = psel && penable && pwrite;
    assign isolate = ctrl_q[`HSLR_CTRL_ISOLATE];
    assign trainedNow = laneSync && !syncPrev_q;
    assign lostNow = !laneSync && syncPrev_q && linkSt_q == hslr_pkg::HSLR_TRAINED;
    assign wdogDone = wdog_q == `HSLR_WDOG_SYMBOLS;
    assign addrOk = paddr == `HSLR_OFF_CTRL || paddr == `HSLR_OFF_STAT
                 || paddr == `HSLR_OFF_EVENT || paddr == `HSLR_OFF_ACKID;

    // Control register
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl_q <= `HSLR_CTRL_RESET;
        end else if (wrEn && paddr == `HSLR_OFF_CTRL) begin
            ctrl_q <= pwdata[5:0];
        end
    end

    // Link state and lane sync watchdog
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            linkSt_q   <= hslr_pkg::HSLR_DOWN;
            syncPrev_q <= 1'b0;
            wdog_q     <= '0;
        end else begin
            syncPrev_q <= laneSync;
            case (linkSt_q)
                hslr_pkg::HSLR_DOWN: begin
                    if (laneSync) begin
                        linkSt_q <= hslr_pkg::HSLR_TRAINED;
                    end
                end
                hslr_pkg::HSLR_TRAINED: begin
                    wdog_q <= '0;
                    if (!laneSync) begin
                        linkSt_q <= hslr_pkg::HSLR_LOST; // R7
                    end
                end
                hslr_pkg::HSLR_LOST: begin
                    if (laneSync) begin
                        linkSt_q <= hslr_pkg::HSLR_TRAINED; // R19
                    end else if (wdogDone) begin
                        linkSt_q <= hslr_pkg::HSLR_FATAL; // R26
                    end else if (symbolTick) begin
                        wdog_q <= wdog_q + 20'h0_0001; // R26
                    end
                end
                hslr_pkg::HSLR_FATAL: begin
                    if (laneSync) begin
                        linkSt_q <= hslr_pkg::HSLR_TRAINED;
                    end
                end
                default: linkSt_q <= hslr_pkg::HSLR_DOWN;
            endcase
        end
    end

    // Event flags; hardware set wins over software clear
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            linkUp_q     <= 1'b0;
            syncLostEv_q <= 1'b0;
        end else begin
            if (wrEn && paddr == `HSLR_OFF_EVENT) begin
                linkUp_q     <= linkUp_q & ~pwdata[`HSLR_EV_LINK_UP]; // R3
                syncLostEv_q <= syncLostEv_q & ~pwdata[`HSLR_EV_SYNC_LOST];
            end
            if ((isolate && trainedNow) || ctrl_q[`HSLR_CTRL_FORCE]) begin
                linkUp_q <= 1'b1; // R1
            end
            if (lostNow) begin
                syncLostEv_q <= 1'b1; // R15
            end
        end
    end

    // Error stop flags and ackID mismatch
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            inStop_q   <= 1'b0;
            outStop_q  <= 1'b0;
            mismatch_q <= 1'b0;
        end else begin
            if (wrEn && paddr == `HSLR_OFF_STAT) begin
                inStop_q   <= inStop_q & ~pwdata[`HSLR_ST_IN_STOP];
                outStop_q  <= outStop_q & ~pwdata[`HSLR_ST_OUT_STOP];
                mismatch_q <= mismatch_q & ~pwdata[`HSLR_ST_MISMATCH];
            end
            if (rxLinkReq && !lostNow) begin
                inStop_q <= 1'b0; // R21
            end
            if (lostNow) begin
                inStop_q  <= 1'b1; // R7
                outStop_q <= 1'b1; // R7
            end
            if (rxPktValid && !inStop_q && !isolate
                && rxPktAckId != rxExp_q) begin
                mismatch_q <= 1'b1; // R10
            end
        end
    end

    // AckID counters
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rxExp_q  <= '0;
            txNext_q <= '0;
        end else if (wrEn && paddr == `HSLR_OFF_ACKID) begin
            rxExp_q  <= pwdata[13:8]; // R11
            txNext_q <= pwdata[5:0];
        end else begin
            if (rxAcceptNext) begin
                rxExp_q <= rxExp_q + 6'h01; // R23
            end
            if (txSendNext) begin
                txNext_q <= txNext_q + 6'h01; // R19
            end
        end
    end

    // Packet gating
    assign linkOk = linkSt_q == hslr_pkg::HSLR_TRAINED && !mismatch_q;
    assign rxAcceptNext = rxPktValid && !inStop_q && linkOk
        && rxPktAckId == rxExp_q && !isolate // R20 R24
        && (rxPktMaint || ctrl_q[`HSLR_CTRL_IN_EN]); // R25
    assign txSendNext = txReqValid && linkOk && !isolate && !ttlExpired
        && (txReqMaint || ctrl_q[`HSLR_CTRL_OUT_EN]); // R24 R25

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rxAccept   <= 1'b0;
            rxAck      <= 1'b0;
            txSend     <= 1'b0;
            txDrop     <= 1'b0;
            txAckId    <= '0;
            queueFlush <= 1'b0;
        end else begin
            rxAccept   <= rxAcceptNext;
            rxAck      <= rxAcceptNext; // R20
            txSend     <= txSendNext;
            txAckId    <= txNext_q; // R19
            txDrop     <= txReqValid && (isolate || ttlExpired); // R6
            queueFlush <= isolate; // R6
        end
    end

    // Link response to link-request
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            linkRespSend  <= 1'b0;
            linkRespAckId <= '0;
        end else begin
            linkRespSend  <= rxLinkReq; // R22
            linkRespAckId <= rxExp_q; // R22
        end
    end

    // Timers during sync loss
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ackTimerRun  <= 1'b0;
            ttlTimerRun  <= 1'b0;
            trainRestart <= 1'b0;
        end else begin
            ackTimerRun  <= linkSt_q == hslr_pkg::HSLR_TRAINED; // R16
            ttlTimerRun  <= 1'b1; // R17
            trainRestart <= lostNow; // R16
        end
    end

    // Interrupt and port-write
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            irq       <= 1'b0;
            portWrite <= 1'b0;
        end else begin
            irq <= ctrl_q[`HSLR_CTRL_LUP_IEN]
                && ((isolate && linkUp_q) || syncLostEv_q); // R2 R3 R15
            portWrite <= ctrl_q[`HSLR_CTRL_PW_EN]
                && ((isolate && trainedNow && !otherPortsUp) // R4 R5
                    || lostNow); // R15
        end
    end

    // APB slave, zero wait states
    logic fatal;
    assign fatal = linkSt_q == hslr_pkg::HSLR_FATAL || mismatch_q
        || oddPartnerFatal; // R8 R10
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addrOk;
            prdata  <= '0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `HSLR_OFF_CTRL: prdata <= {26'h000_0000, ctrl_q};
                    `HSLR_OFF_STAT: prdata <= {26'h000_0000, mismatch_q,
                        fatal, outStop_q, inStop_q, linkOk, // R14
                        linkSt_q != hslr_pkg::HSLR_TRAINED};
                    `HSLR_OFF_EVENT: prdata <= {30'h0000_0000,
                        syncLostEv_q, linkUp_q};
                    `HSLR_OFF_ACKID: prdata <= {18'h0_0000, rxExp_q,
                        2'b00, txNext_q};
                    default: prdata <= '0;
                endcase
            end
        end
    end

    sequence s_restart_then_idle;
        trainRestart ##1 !ackTimerRun;
    endsequence

    a_rx_no_ack_stop: assert property (@(posedge clk_sys) // R20
        disable iff (!nrst) inStop_q |=> !rxAck)
        else $error("ack while input stopped");
    a_resp_follows_req: assert property (@(posedge clk_sys) // R22
        disable iff (!nrst)
        rxLinkReq |=> linkRespSend && linkRespAckId == $past(rxExp_q))
        else $error("missing link response");
    a_iso_no_send: assert property (@(posedge clk_sys) // R24
        disable iff (!nrst) isolate |=> !txSend && !rxAccept)
        else $error("traffic while isolated");
    a_loss_flags_set: assert property (@(posedge clk_sys) // R7
        disable iff (!nrst) lostNow |=> inStop_q && outStop_q && !linkOk)
        else $error("loss flags not set");
    a_ttl_runs: assert property (@(posedge clk_sys) // R17
        disable iff (!nrst) $past(nrst) |-> ttlTimerRun)
        else $error("ttl timer stopped");
    a_restart_on_loss: assert property (@(posedge clk_sys) // R16
        disable iff (!nrst) lostNow |=> s_restart_then_idle)
        else $error("no restart after sync loss");
    a_link_up_only: assert property (@(posedge clk_sys) // R1
        disable iff (!nrst) !linkUp_q && !(isolate && trainedNow)
        && !ctrl_q[`HSLR_CTRL_FORCE] |=> !linkUp_q)
        else $error("link-up event set while not isolated");
endmodule : hslr_port
`default_nettype wire

// ===== verilog/hslr_consts.svh
// Offsets, fields, reset values and timing counts for the link recovery block
`ifndef HSLR_CONSTS_SVH
`define HSLR_CONSTS_SVH
`define HSLR_OFF_CTRL       12'h000
`define HSLR_OFF_STAT       12'h004
`define HSLR_OFF_EVENT      12'h008
`define HSLR_OFF_ACKID      12'h00C
`define HSLR_CTRL_ISOLATE   0
`define HSLR_CTRL_OUT_EN    1
`define HSLR_CTRL_IN_EN     2
`define HSLR_CTRL_LUP_IEN   3
`define HSLR_CTRL_FORCE     4
`define HSLR_CTRL_PW_EN     5
`define HSLR_CTRL_RESET     6'h01
`define HSLR_ST_NOT_TRAINED 0
`define HSLR_ST_USABLE      1
`define HSLR_ST_IN_STOP     2
`define HSLR_ST_OUT_STOP    3
`define HSLR_ST_FATAL       4
`define HSLR_ST_MISMATCH    5
`define HSLR_EV_LINK_UP     0
`define HSLR_EV_SYNC_LOST   1
`define HSLR_WDOG_SYMBOLS   20'hF_FFFF
`endif

// ===== verilog/hslr_pkg.sv
// Types for the link recovery block
`default_nettype none
package hslr_pkg;
    typedef enum logic [1:0] {
        HSLR_DOWN    = 2'b00,
        HSLR_TRAINED = 2'b01,
        HSLR_LOST    = 2'b11,
        HSLR_FATAL   = 2'b10
    } hslr_link_t;
endpackage : hslr_pkg
`default_nettype wire

// ===== verilog/hslr_sync2.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module hslr_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : hslr_sync2
`default_nettype wire

// ===== bench/hslr_partner.sv
// Behavioural link partner for the link recovery port
`timescale 1ns/1ps
`default_nettype none
module hslr_partner (
    // Clock and bench commands
    input  wire logic       clk_sys,
    input  wire logic       present,
    input  wire logic       doRecover,
    input  wire logic       doPkt,
    input  wire logic [5:0] pktAck,
    // From the port
    input  wire logic       linkRespSend,
    input  wire logic [5:0] linkRespAckId,
    // To the port
    output logic            laneSyncPin,
    output logic            symbolTick,
    output logic            rxLinkReq,
    output logic            rxPktValid,
    output logic            rxPktMaint,
    output logic [5:0]      rxPktAckId,
    // Status to the bench
    output logic [5:0]      respAck,
    output logic            busy
);
    logic [1:0] st = 2'd0;
    int         wait_n = 0;
    initial begin
        {laneSyncPin, symbolTick, rxLinkReq, rxPktValid, rxPktMaint} = '0;
        rxPktAckId = 6'h2A;
        respAck = 6'h00;
    end
    assign busy = (st != 2'd0);
    // Lane present only while inserted; symbol ticks stop when removed
    always @(posedge clk_sys) begin
        laneSyncPin <= present;
        symbolTick <= present & ~symbolTick;
    end
    always @(posedge clk_sys) begin
        rxLinkReq <= 1'b0;
        rxPktValid <= 1'b0;
        rxPktAckId <= ~rxPktAckId;
        case (st)
            2'd0: begin
                if (doPkt) begin
                    rxPktValid <= 1'b1;
                    rxPktAckId <= pktAck;
                end else if (doRecover) begin
                    rxLinkReq <= 1'b1;
                    wait_n <= 0;
                    st <= 2'd1;
                end
            end
            2'd1: begin
                wait_n <= wait_n + 1;
                if (linkRespSend === 1'b1) begin
                    respAck <= linkRespAckId;
                    st <= 2'd2;
                end else if (wait_n > 50) begin
                    st <= 2'd0;
                end
            end
            default: begin
                rxPktValid <= 1'b1;
                rxPktAckId <= respAck;
                st <= 2'd0;
            end
        endcase
    end
endmodule : hslr_partner
`default_nettype wire

// ===== bench/test_hslr_port.sv
// Self-checking bench for the link recovery port
`timescale 1ns/1ps
`default_nettype none
module test_hslr_port;
    // Bench-driven signals
    logic        clk_sys = 0, nrst = 0;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rdat, v;
    logic        rerr, present = 0, doRecover = 0, doPkt = 0;
    logic        txReqValid = 0, oddFatal = 0;
    logic [5:0]  pktAck = 6'h00, tx, rx, lastTx, respAck, rxPktAckId;
    // Design outputs
    logic [31:0] prdata;
    logic        pready, pslverr, irq, portWrite, linkRespSend, rxAck;
    logic        rxAccept, txSend, txDrop, queueFlush, ackTimerRun;
    logic        ttlTimerRun, trainRestart, busy, laneSyncPin, symbolTick;
    logic        rxLinkReq, rxPktValid, rxPktMaint;
    logic [5:0]  linkRespAckId, txAckId;
    int          n_errors = 0, check_count = 0, cyc = 0, k;
    int          nPw = 0, nSend = 0, nDrop = 0, nAck = 0, nAcc = 0, nRst = 0;
    hslr_port uut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .laneSyncPin(laneSyncPin), .symbolTick(symbolTick),
        .oddPartnerFatal(oddFatal), .otherPortsUp(1'b0),
        .rxLinkReq(rxLinkReq),
        .rxPktValid(rxPktValid), .rxPktMaint(rxPktMaint),
        .rxPktAckId(rxPktAckId), .txReqValid(txReqValid), .txReqMaint(1'b0),
        .ttlExpired(1'b0), .irq(irq), .portWrite(portWrite),
        .linkRespSend(linkRespSend), .linkRespAckId(linkRespAckId),
        .rxAck(rxAck), .rxAccept(rxAccept), .txSend(txSend), .txDrop(txDrop),
        .txAckId(txAckId), .queueFlush(queueFlush), .ackTimerRun(ackTimerRun),
        .ttlTimerRun(ttlTimerRun), .trainRestart(trainRestart));
    hslr_partner partner (.clk_sys(clk_sys), .present(present),
        .doRecover(doRecover), .doPkt(doPkt), .pktAck(pktAck),
        .linkRespSend(linkRespSend), .linkRespAckId(linkRespAckId),
        .laneSyncPin(laneSyncPin), .symbolTick(symbolTick),
        .rxLinkReq(rxLinkReq), .rxPktValid(rxPktValid),
        .rxPktMaint(rxPktMaint), .rxPktAckId(rxPktAckId),
        .respAck(respAck), .busy(busy));
    always #5 clk_sys = ~clk_sys;
    // Pulse counters and hang limit
    always @(posedge clk_sys) begin
        nPw += (portWrite === 1'b1);
        nDrop += (txDrop === 1'b1);
        nAck += (rxAck === 1'b1);
        nAcc += (rxAccept === 1'b1);
        nRst += (trainRestart === 1'b1);
        if (txSend === 1'b1) begin
            nSend++;
            lastTx = txAckId;
        end
        cyc++;
        if (cyc == 50000) begin
            n_errors++;
            stop_test();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
    endtask : apb
    task poll(input logic [11:0] a, input int b, input logic val);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0000_0000);
            n++;
        end while (rdat[b] !== val && n < 300);
    endtask : poll
    task stop_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    initial begin
        void'($urandom(63896));
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        // Reset value, unmapped address, control readback
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rdat, 32'h0000_0001);
        apb(1'b1, 12'h010, 32'h0000_00FF);
        chk({31'h0000_0000, rerr}, 32'h0000_0001);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        for (k = 0; k < 4; k++) begin
            v = $urandom & 32'h0000_002F;
            apb(1'b1, 12'h000, v);
            apb(1'b0, 12'h000, 32'h0000_0000);
            chk(rdat, v);
        end
        // Insertion while isolated
        apb(1'b1, 12'h000, 32'h0000_0029);
        k = nPw;
        present <= 1'b1;
        poll(12'h008, 0, 1'b1);
        chk(rdat[0], 1'b1);
        repeat (4) @(posedge clk_sys);
        chk(nPw - k, 1);
        chk(irq, 1'b1);
        k = nDrop;
        @(posedge clk_sys) txReqValid <= 1'b1;
        repeat (4) @(posedge clk_sys);
        txReqValid <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(nSend, 0);
        chk(nDrop > k, 1'b1);
        chk(queueFlush, 1'b1);
        apb(1'b1, 12'h008, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'b0);
        // Transmit gating and ackID
        tx = $urandom;
        rx = $urandom;
        apb(1'b1, 12'h00C, {18'h0000, rx, 2'b00, tx});
        apb(1'b1, 12'h000, 32'h0000_0002);
        @(posedge clk_sys) txReqValid <= 1'b1;
        for (k = 0; k < 40 && nSend == 0; k++) @(posedge clk_sys);
        txReqValid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(lastTx, 6'(tx + nSend - 1));
        apb(1'b1, 12'h000, 32'h0000_0000);
        k = nSend;
        @(posedge clk_sys) txReqValid <= 1'b1;
        repeat (6) @(posedge clk_sys);
        txReqValid <= 1'b0;
        chk(nSend - k, 0);
        // Removal
        k = nRst;
        present <= 1'b0;
        poll(12'h004, 0, 1'b1);
        chk(rdat[3:0], 4'hD);
        chk(nRst > k, 1'b1);
        chk({ackTimerRun, ttlTimerRun}, 2'b01);
        // Resync, ignored packet, link request recovery
        present <= 1'b1;
        poll(12'h004, 0, 1'b0);
        rx = $urandom;
        apb(1'b1, 12'h00C, {18'h0000, rx, 2'b00, tx});
        apb(1'b1, 12'h000, 32'h0000_0004);
        k = nAck;
        @(posedge clk_sys) begin
            pktAck <= rx;
            doPkt <= 1'b1;
        end
        @(posedge clk_sys) doPkt <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(nAck - k, 0);
        k = nAcc;
        @(posedge clk_sys) doRecover <= 1'b1;
        @(posedge clk_sys) doRecover <= 1'b0;
        repeat (60) @(posedge clk_sys);
        chk(respAck, rx);
        chk(nAcc - k, 1);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rdat[2], 1'b0);
        chk(rdat[4], 1'b0);
        oddFatal <= 1'b1;
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rdat[4], 1'b1);
        oddFatal <= 1'b0;
        // Partner without recovery registers: receive ackID zero
        k = nAcc;
        apb(1'b1, 12'h00C, {18'h0000, 6'h00, 2'b00, tx});
        @(posedge clk_sys) begin
            pktAck <= 6'h00;
            doPkt <= 1'b1;
        end
        @(posedge clk_sys) doPkt <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(nAcc - k, 1);
        stop_test();
    end
endmodule : test_hslr_port
`default_nettype wire
